// *** verilog/adcig_top.sv ***
// Converter completion interrupt gating with an AXI4-Lite register slave.
// Assumes the converter pins are asynchronous and the core sits on clk_in.
`timescale 1ns/100ps
`default_nettype none
module adcig_top
    import adcig_pkg::*;
#(
    parameter int unsigned CMPB_CYCLES = CMPB_CYCLES_DEF
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic [2:0] s_axi_awprot_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [DATA_W-1:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic [2:0] s_axi_arprot_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [DATA_W-1:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic conv_done_in,
    input wire logic [RESULT_W-1:0] conv_data_in,
    output logic conv_start_out,
    output logic conv_chan_out,
    input wire logic global_mask_flag_in,
    input wire logic core_ack_in,
    output logic irq_req_out,
    output logic [PRIO_W-1:0] priority_level_out
);
    adcig_scan_if sif ();

    // Write channel holding registers
    logic aw_full_q, aw_full_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic w_full_q, w_full_d;
    logic [DATA_W-1:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    // Read channel registers
    logic rvalid_q, rvalid_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    // Control and status
    logic srcen_q, srcen_d;
    logic lie_q, lie_d;
    logic grp_q, grp_d;
    logic [PRIO_W-1:0] prio_q, prio_d;
    logic pend_q, pend_d;
    logic start_q, start_d;
    // Converter pin synchronisers
    logic done_s1_q, done_s2_q, done_s3_q;
    logic [RESULT_W-1:0] data_s1_q, data_s2_q;

    logic do_write;
    logic irq_req;
    logic local_evt;
    adcig_reg_e wr_reg;
    adcig_reg_e rd_reg;

    assign wr_reg = adcig_decode(awaddr_q);
    assign rd_reg = adcig_decode(s_axi_araddr_in);
    assign do_write = aw_full_q && w_full_q && !bvalid_q;

    // Only a completion seen with the local enable set becomes a request
    assign local_evt = sif.scan_done && lie_q;

    // Four gates in series; priority level 0 means never delivered
    assign irq_req = pend_q && srcen_q && (prio_q != PRIO_OFF)
                     && global_mask_flag_in;

    always_comb begin
        aw_full_d = aw_full_q;
        awaddr_d = awaddr_q;
        w_full_d = w_full_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        srcen_d = srcen_q;
        lie_d = lie_q;
        grp_d = grp_q;
        prio_d = prio_q;
        pend_d = pend_q;
        start_d = 1'b0;

        if (s_axi_awvalid_in && !aw_full_q) begin
            aw_full_d = 1'b1;
            awaddr_d = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !w_full_q) begin
            w_full_d = 1'b1;
            wdata_d = s_axi_wdata_in;
            wstrb_d = s_axi_wstrb_in;
        end
        if (s_axi_bvalid_out && s_axi_bready_in) begin
            bvalid_d = 1'b0;
        end

        // Acceptance by the core retires the request
        if (irq_req && core_ack_in) begin
            pend_d = 1'b0;
        end

        if (do_write) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            if (wstrb_q[0]) begin
                unique case (wr_reg)
                    REG_CTRL: begin
                        srcen_d = wdata_q[CTRL_SRCEN_BIT];
                        lie_d = wdata_q[CTRL_LIE_BIT];
                        grp_d = wdata_q[CTRL_GRP_BIT];
                    end
                    REG_PRIO: prio_d = wdata_q[PRIO_LSB +: PRIO_W];
                    REG_STAT: begin
                        // Writing 1 leaves the flag alone
                        if (!wdata_q[STAT_PEND_BIT]) begin
                            pend_d = 1'b0;
                        end
                    end
                    REG_START: start_d = wdata_q[START_BIT];
                    default: begin
                    end
                endcase
            end
        end

        // Set after clear so an event in the clearing cycle survives
        if (local_evt) begin
            pend_d = 1'b1;
        end

        if (s_axi_rvalid_out && s_axi_rready_in) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid_in && !rvalid_q) begin
            rvalid_d = 1'b1;
            rdata_d = DATA_ZERO;
            rresp_d = RESP_OKAY;
            unique case (rd_reg)
                REG_CTRL: begin
                    rdata_d[CTRL_SRCEN_BIT] = srcen_q;
                    rdata_d[CTRL_LIE_BIT] = lie_q;
                    rdata_d[CTRL_GRP_BIT] = grp_q;
                end
                REG_PRIO: rdata_d[PRIO_LSB +: PRIO_W] = prio_q;
                REG_STAT: begin
                    rdata_d[STAT_PEND_BIT] = pend_q;
                    rdata_d[STAT_BUSY_BIT] = sif.busy;
                    rdata_d[STAT_IRQ_BIT] = irq_req;
                    rdata_d[STAT_GMASK_BIT] = global_mask_flag_in;
                end
                REG_START: rdata_d = DATA_ZERO;
                REG_RES0: rdata_d[RESULT_W-1:0] = sif.result0;
                REG_RES1: rdata_d[RESULT_W-1:0] = sif.result1;
                default: rresp_d = RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            aw_full_q <= 1'b0;
            awaddr_q <= '0;
            w_full_q <= 1'b0;
            wdata_q <= DATA_ZERO;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= DATA_ZERO;
            rresp_q <= RESP_OKAY;
            srcen_q <= 1'b0;
            lie_q <= 1'b0;
            grp_q <= 1'b0;
            prio_q <= PRIO_RST;
            pend_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            aw_full_q <= aw_full_d;
            awaddr_q <= awaddr_d;
            w_full_q <= w_full_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            srcen_q <= srcen_d;
            lie_q <= lie_d;
            grp_q <= grp_d;
            prio_q <= prio_d;
            pend_q <= pend_d;
            start_q <= start_d;
        end
    end

    // Data settle before the done edge, so two stages suffice for both
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            done_s1_q <= 1'b0;
            done_s2_q <= 1'b0;
            done_s3_q <= 1'b0;
            data_s1_q <= RESULT_RST;
            data_s2_q <= RESULT_RST;
        end else begin
            done_s1_q <= conv_done_in;
            done_s2_q <= done_s1_q;
            done_s3_q <= done_s2_q;
            data_s1_q <= conv_data_in;
            data_s2_q <= data_s1_q;
        end
    end

    assign sif.start = start_q;
    assign sif.group_mode = grp_q;
    assign sif.conv_done = done_s2_q && !done_s3_q;
    assign sif.conv_data = data_s2_q;

    adcig_seq #(
        .CMPB_CYCLES(CMPB_CYCLES)
    ) u_seq (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .sif(sif),
        .conv_start_out(conv_start_out),
        .conv_chan_out(conv_chan_out)
    );

    assign s_axi_awready_out = !aw_full_q;
    assign s_axi_wready_out = !w_full_q;
    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_arready_out = !rvalid_q;
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rdata_out = rdata_q;
    assign s_axi_rresp_out = rresp_q;
    assign irq_req_out = irq_req;
    assign priority_level_out = prio_q;
endmodule
`default_nettype wire

// *** verilog/adcig_pkg.sv ***
// Constants, register map, types and decoding shared by the converter
// completion interrupt gating block. Assumes a single 125 MHz clock.
// Functional notes
// - A request reaches the core only while the core's global mask flag is 1.
// - A request is forwarded only when the source enable is set and its priority level permits delivery.
// - The converter raises its completion request only while its local interrupt enable is set.
// - A completion request sets the pending request flag to 1.
// - The source carries a four-bit priority level field in bits 3 down to 0.
// - After a single-channel conversion the result is stored first and then the completion request is raised.
// - In a two-channel scan the completion request is raised once, after the last channel finishes.
// - Compare match A starts channel 0 and compare match B, 150 us after the start, starts channel 1.
// - Writing 0 to the pending request flag clears it.
package adcig_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned RESULT_W = 12;
    localparam int unsigned PRIO_W = 4;
    localparam int unsigned CNT_W = 24;

    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_PRIO = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_START = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_RES0 = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_RES1 = 8'h14;

    localparam int unsigned CTRL_SRCEN_BIT = 0;
    localparam int unsigned CTRL_LIE_BIT = 1;
    localparam int unsigned CTRL_GRP_BIT = 2;
    localparam int unsigned PRIO_LSB = 0;
    localparam int unsigned STAT_PEND_BIT = 0;
    localparam int unsigned STAT_BUSY_BIT = 1;
    localparam int unsigned STAT_IRQ_BIT = 2;
    localparam int unsigned STAT_GMASK_BIT = 3;
    localparam int unsigned START_BIT = 0;

    localparam logic [PRIO_W-1:0] PRIO_OFF = 4'h0;
    localparam logic [PRIO_W-1:0] PRIO_RST = 4'h0;
    localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned CMPB_TIME_US = 150;
    localparam int unsigned CMPB_CYCLES_DEF = CMPB_TIME_US * CLK_MHZ;

    typedef enum logic [1:0] {SCAN_IDLE, SCAN_CONV0, SCAN_WAIT_B, SCAN_CONV1} adcig_scan_e;

    typedef enum logic [2:0] {REG_CTRL, REG_PRIO, REG_STAT, REG_START, REG_RES0, REG_RES1, REG_NONE} adcig_reg_e;

    function automatic adcig_reg_e adcig_decode(input logic [ADDR_W-1:0] addr);
        adcig_reg_e r;
        unique case (addr)
            ADDR_CTRL: r = REG_CTRL;
            ADDR_PRIO: r = REG_PRIO;
            ADDR_STAT: r = REG_STAT;
            ADDR_START: r = REG_START;
            ADDR_RES0: r = REG_RES0;
            ADDR_RES1: r = REG_RES1;
            default: r = REG_NONE;
        endcase
        return r;
    endfunction

endpackage

// *** verilog/adcig_scan_if.sv ***
// Link between the register side and the scan sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface adcig_scan_if;
    import adcig_pkg::*;
    logic start;
    logic group_mode;
    logic conv_done;
    logic [RESULT_W-1:0] conv_data;
    logic busy;
    logic scan_done;
    logic [RESULT_W-1:0] result0;
    logic [RESULT_W-1:0] result1;

    modport ctl (output start, output group_mode, output conv_done, output conv_data,
                 input busy, input scan_done, input result0, input result1);
    modport seq (input start, input group_mode, input conv_done, input conv_data,
                 output busy, output scan_done, output result0, output result1);
endinterface
`default_nettype wire

// *** verilog/adcig_seq.sv ***
// Scan sequencer: timer compare matches A and B and the channel order.
// Assumes conv_done is a one-cycle pulse already on this clock.
`timescale 1ns/100ps
`default_nettype none
module adcig_seq
    import adcig_pkg::*;
#(
    parameter int unsigned CMPB_CYCLES = CMPB_CYCLES_DEF
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    adcig_scan_if.seq sif,
    output logic conv_start_out,
    output logic conv_chan_out
);
    localparam logic [CNT_W-1:0] CMPB_LAST = CNT_W'(CMPB_CYCLES - 1);

    adcig_scan_e state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic cmpb_q, cmpb_d;
    logic start_q, start_d;
    logic chan_q, chan_d;
    logic done_q, done_d;
    logic [RESULT_W-1:0] res0_q, res0_d, res1_q, res1_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        cmpb_d = cmpb_q;
        start_d = 1'b0;
        chan_d = chan_q;
        done_d = 1'b0;
        res0_d = res0_q;
        res1_d = res1_q;
        // Compare match B timer runs from the start trigger; it saturates so a slow channel 0 cannot miss it
        if (state_q != SCAN_IDLE && !cmpb_q) begin
            cnt_d = cnt_q + CNT_W'(1);
            cmpb_d = (cnt_q == CMPB_LAST);
        end
        unique case (state_q)
            SCAN_IDLE: begin
                if (sif.start) begin
                    // Compare match A starts channel 0 at once
                    cnt_d = '0;
                    cmpb_d = 1'b0;
                    start_d = 1'b1;
                    chan_d = 1'b0;
                    state_d = SCAN_CONV0;
                end
            end
            SCAN_CONV0: begin
                if (sif.conv_done) begin
                    res0_d = sif.conv_data;
                    if (sif.group_mode) begin
                        state_d = SCAN_WAIT_B;
                    end else begin
                        done_d = 1'b1;
                        state_d = SCAN_IDLE;
                    end
                end
            end
            SCAN_WAIT_B: begin
                if (cmpb_q) begin
                    start_d = 1'b1;
                    chan_d = 1'b1;
                    state_d = SCAN_CONV1;
                end
            end
            SCAN_CONV1: begin
                if (sif.conv_done) begin
                    res1_d = sif.conv_data;
                    done_d = 1'b1;
                    state_d = SCAN_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= SCAN_IDLE;
            cnt_q <= '0;
            cmpb_q <= 1'b0;
            start_q <= 1'b0;
            chan_q <= 1'b0;
            done_q <= 1'b0;
            res0_q <= RESULT_RST;
            res1_q <= RESULT_RST;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            cmpb_q <= cmpb_d;
            start_q <= start_d;
            chan_q <= chan_d;
            done_q <= done_d;
            res0_q <= res0_d;
            res1_q <= res1_d;
        end
    end

    assign conv_start_out = start_q;
    assign conv_chan_out = chan_q;
    assign sif.busy = (state_q != SCAN_IDLE);
    assign sif.scan_done = done_q;
    assign sif.result0 = res0_q;
    assign sif.result1 = res1_q;
endmodule
`default_nettype wire

// *** verif/adcig_assertions.sv ***
// Port checker for adcig_top: gating, scan timing and bus answers.
// Assumes one clock; bound to every adcig_top instance below.
`timescale 1ns/100ps
`default_nettype none
module adcig_assertions
    import adcig_pkg::*;
#(
    parameter int unsigned CMPB_CYCLES = CMPB_CYCLES_DEF
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic s_axi_rvalid_out,
    input wire logic conv_done_in,
    input wire logic conv_start_out,
    input wire logic conv_chan_out,
    input wire logic global_mask_flag_in,
    input wire logic core_ack_in,
    input wire logic irq_req_out,
    input wire logic [PRIO_W-1:0] priority_level_out
);
    logic [15:0] ch0_age_q;
    logic [15:0] done_age_q;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    // Ages saturate so a long idle run never wraps into a false pass
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ch0_age_q <= '0;
            done_age_q <= '0;
        end else begin
            ch0_age_q <= (conv_start_out && !conv_chan_out) ? '0 : ch0_age_q + {15'h0, ch0_age_q != 16'hFFFF};
            done_age_q <= conv_done_in ? '0 : done_age_q + {15'h0, done_age_q != 16'hFFFF};
        end
    end

    irq_gmask_a: assert property (irq_req_out |-> global_mask_flag_in)
        else $error("request without global mask");
    prio_gate_a: assert property (irq_req_out |-> priority_level_out != PRIO_OFF)
        else $error("request at priority zero");
    start_pulse_a: assert property (conv_start_out |=> !conv_start_out)
        else $error("start longer than one cycle");
    chan_hold_a: assert property ($changed(conv_chan_out) |-> conv_start_out)
        else $error("channel changed without a start");
    ch1_delay_a: assert property (conv_start_out && conv_chan_out |-> ch0_age_q >= 16'(CMPB_CYCLES))
        else $error("channel 1 started early");
    // Set wins over accept, so only judge accepts well clear of a completion
    ack_clear_a: assert property (irq_req_out && core_ack_in && done_age_q > 16'h2 |=> !irq_req_out)
        else $error("accepted request still pending");
    pend_hold_a: assert property (irq_req_out && !core_ack_in && !s_axi_wvalid_in && s_axi_wready_out |=> irq_req_out || !global_mask_flag_in)
        else $error("pending request lost");
    rd_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read answer late");
    wr_answer_a: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out |-> ##2 s_axi_bvalid_out)
        else $error("write answer late");

    cover property (conv_start_out && conv_chan_out);
    cover property (irq_req_out && core_ack_in);
    cover property (s_axi_bvalid_out && s_axi_arvalid_in);
endmodule
bind adcig_top adcig_assertions #(.CMPB_CYCLES(CMPB_CYCLES)) u_chk (.*);
`default_nettype wire

// *** verif/adcig_far_model.sv ***
// Converter and core stand-in: answers each start, accepts on request.
// Assumes start is a one-cycle pulse on clk_in.
`timescale 1ns/100ps
`default_nettype none
module adcig_far_model
    import adcig_pkg::*;
#(
    parameter int DONE_DLY = 6
) (
    input wire logic clk_in,
    input wire logic start_in,
    input wire logic chan_in,
    input wire logic irq_in,
    input wire logic accept_en_in,
    output logic done_out,
    output logic [RESULT_W-1:0] data_out,
    output logic ack_out
);
    int cnt = 0;

    initial begin
        done_out = '0;
        data_out = 12'hFFF;
        ack_out = '0;
    end

    // Core takes a request only while allowed; one-cycle accept pulse
    always @(posedge clk_in) begin
        ack_out <= irq_in && accept_en_in && !ack_out;
        cnt <= start_in ? 1 : (cnt != 0 ? cnt + 1 : 0);
        if (cnt == 2) data_out <= chan_in ? 12'hA5C : 12'h3B1;
        if (cnt == DONE_DLY) done_out <= '1;
        if (cnt == DONE_DLY + 4) done_out <= '0;
        // Result is no longer held, so show its inverse
        if (cnt == DONE_DLY + 8) data_out <= ~data_out;
    end
endmodule
`default_nettype wire

// *** verif/adcig_tb_top.sv ***
// Self-checking bench for adcig_top over AXI4-Lite and the far model.
// Assumes a short compare B count so the group scan stays brief.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module adcig_tb_top;
    import adcig_pkg::*;
    localparam int unsigned CMPB = 40;
    logic clk_in = 0, arst_n_in = 0, s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
    logic s_axi_arvalid_in = 0, s_axi_rready_in = 0, global_mask_flag_in = 0, accept_en = 0;
    logic [ADDR_W-1:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
    logic [2:0] s_axi_awprot_in = '0, s_axi_arprot_in = '0;
    logic [DATA_W-1:0] s_axi_wdata_in = '0, s_axi_rdata_out, rd;
    logic [3:0] s_axi_wstrb_in = 4'hF;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic conv_done_in, core_ack_in, conv_start_out, conv_chan_out, irq_req_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, resp;
    logic [RESULT_W-1:0] conv_data_in;
    logic [PRIO_W-1:0] priority_level_out;
    int mismatches = 0, total_checks = 0, cyc = 0, starts = 0;

    adcig_top #(.CMPB_CYCLES(CMPB)) u_dut (.*);
    adcig_far_model u_far (.clk_in(clk_in), .start_in(conv_start_out), .chan_in(conv_chan_out),
        .irq_in(irq_req_out), .accept_en_in(accept_en), .done_out(conv_done_in),
        .data_out(conv_data_in), .ack_out(core_ack_in));

    always #4 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        starts <= starts + int'(conv_start_out);
    end

    task automatic finish_test();
        if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic hang();
        mismatches++;
        $display("ERROR wait_bound exp 1 got 0");
        finish_test();
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= '1;
        s_axi_wvalid_in <= '1;
        s_axi_bready_in <= '1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
            if (s_axi_awready_out) s_axi_awvalid_in <= '0;
            if (s_axi_wready_out) s_axi_wvalid_in <= '0;
        end while (s_axi_bvalid_out !== 1'b1 && n < 50);
        s_axi_bready_in <= '0;
        resp = s_axi_bresp_out;
        if (n >= 50) hang();
    endtask

    task automatic ard(input logic [7:0] a);
        int n;
        @(posedge clk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= '1;
        s_axi_rready_in <= '1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
            if (s_axi_arready_out) s_axi_arvalid_in <= '0;
        end while (s_axi_rvalid_out !== 1'b1 && n < 50);
        s_axi_rready_in <= '0;
        rd = s_axi_rdata_out;
        resp = s_axi_rresp_out;
        if (n >= 50) hang();
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        ard(a);
        `CHK(nm, e, rd & m)
    endtask

    task automatic poll(input logic [31:0] m, input logic [31:0] e);
        int n;
        n = 0;
        do begin
            ard(ADDR_STAT);
            n++;
        end while ((rd & m) !== e && n < 50);
        if (n >= 50) hang();
    endtask

    task automatic irqchk(input logic e);
        @(negedge clk_in);
        `CHK("irq_req", e, irq_req_out)
    endtask

    task automatic wait_start(input int k);
        int n;
        for (n = 0; n < 300 && starts != k; n++) @(posedge clk_in);
        if (n >= 300) hang();
    endtask

    task automatic t_reset();
        `CHK("prio_out", PRIO_RST, priority_level_out)
        rchk("ctrl", ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
        rchk("stat", ADDR_STAT, 32'hFFFFFFFF, 32'h0);
        ard(8'h20);
        `CHK("rd_resp", RESP_SLVERR, resp)
        axw(8'h20, 32'hFFFFFFFF);
        `CHK("wr_resp", RESP_SLVERR, resp)
    endtask

    task automatic t_single();
        axw(ADDR_CTRL, 32'h3);
        `CHK("wr_ok", RESP_OKAY, resp)
        axw(ADDR_PRIO, 32'hFFFFFFF5);
        rchk("prio", ADDR_PRIO, 32'hFFFFFFFF, 32'h5);
        `CHK("rd_ok", RESP_OKAY, resp)
        `CHK("prio_out", 4'h5, priority_level_out)
        // Byte lane 0 off: the write is answered but changes nothing
        s_axi_wstrb_in <= 4'hE;
        axw(ADDR_PRIO, 32'h0);
        s_axi_wstrb_in <= 4'hF;
        `CHK("prio_keep", 4'h5, priority_level_out)
        axw(ADDR_START, 32'h1);
        poll(32'h1, 32'h1);
        rchk("res0", ADDR_RES0, 32'hFFFFFFFF, 32'h3B1);
        irqchk(1'b0);
        @(posedge clk_in);
        global_mask_flag_in <= '1;
        irqchk(1'b1);
        axw(ADDR_PRIO, 32'h0);
        irqchk(1'b0);
        axw(ADDR_PRIO, 32'h5);
        axw(ADDR_CTRL, 32'h2);
        irqchk(1'b0);
        axw(ADDR_CTRL, 32'h3);
        irqchk(1'b1);
        axw(ADDR_STAT, 32'h1);
        irqchk(1'b1);
        axw(ADDR_STAT, 32'h0);
        irqchk(1'b0);
    endtask

    task automatic t_local();
        int k;
        k = starts;
        axw(ADDR_CTRL, 32'h1);
        axw(ADDR_START, 32'h1);
        wait_start(k + 1);
        poll(32'h2, 32'h0);
        rchk("pend", ADDR_STAT, 32'h1, 32'h0);
        irqchk(1'b0);
    endtask

    task automatic t_group();
        int k;
        int t0;
        k = starts;
        axw(ADDR_CTRL, 32'h7);
        axw(ADDR_START, 32'h1);
        wait_start(k + 1);
        t0 = cyc;
        `CHK("chan_a", 1'b0, conv_chan_out)
        // A second start while busy must not begin another scan
        axw(ADDR_START, 32'h1);
        wait_start(k + 2);
        `CHK("chan_b", 1'b1, conv_chan_out)
        `CHK("gap_b", 1'b1, (cyc - t0) inside {[CMPB:CMPB + 1]})
        irqchk(1'b0);
        poll(32'h1, 32'h1);
        rchk("res1", ADDR_RES1, 32'hFFFFFFFF, 32'hA5C);
        `CHK("starts", k + 2, starts)
        @(posedge clk_in);
        accept_en <= '1;
        // Accept is one edge late in the core model, pending clears one edge after that
        irqchk(1'b1);
        repeat (2) @(posedge clk_in);
        accept_en <= '0;
        irqchk(1'b0);
        rchk("pend", ADDR_STAT, 32'h1, 32'h0);
    endtask

    initial begin
        repeat (3) @(posedge clk_in);
        arst_n_in <= '1;
        t_reset();
        t_single();
        t_local();
        t_group();
        finish_test();
    end
endmodule
`default_nettype wire
